// ---- logic/duart_port_pkg.sv ----
// constants, carrier structs and state records for the dual serial host port
// assumes one 200 MHz clock and a synchronous active-high reset
package duart_port_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_PULSE_NS = 40;
	// least time: round up to whole cycles
	localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] RST_CNT_MAX = 4'(RST_PULSE_CYC);

	////////////////////////////////////////////////////////////////////////////
	// field positions and channel codes
	localparam int MCR_OP2_BIT = 3;
	localparam int MCR_IR_BIT = 6;
	localparam int NUM_CHAN = 2;
	localparam logic CHAN_A = 1'h0;
	localparam logic CHAN_B = 1'h1;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic chan;
		logic [2:0] addr;
		logic [7:0] data;
	} reg_access_t;

	typedef struct packed {
		logic [7:0] modem_control_reg;
		logic ir_invert;
		logic auto_cts;
		logic tx_bit;
		logic tx_busy;
		logic irq_pending;
		logic tx_space;
		logic rx_avail;
		logic rts_on;
		logic dtr_on;
	} chan_ctrl_t;

	typedef struct packed {
		logic serial_in;
		logic cts_n;
		logic dsr_n;
		logic cd_n;
		logic ri_n;
	} modem_in_t;

	typedef struct packed {
		logic serial_out;
		logic rts_n;
		logic dtr_n;
		logic op2_n;
		logic tx_rdy_n;
		logic rx_rdy_n;
		logic irq_o;
		logic irq_oe;
	} chan_pins_t;

	typedef struct packed {
		logic rx_bit;
		logic cts;
		logic dsr;
		logic cd;
		logic ri;
		logic tx_allowed;
	} chan_stat_t;

	typedef struct packed {
		logic strap;
		logic reset_pin;
		logic rd_n;
		logic wr_n;
		logic csa_n;
		logic csb_n;
		logic [2:0] addr;
		logic [7:0] din;
	} bus_pins_t;

	////////////////////////////////////////////////////////////////////////////
	// state records and reset values
	typedef struct packed {
		modem_in_t meta;
		modem_in_t sync;
		chan_pins_t pins;
		chan_stat_t stat;
	} chan_state_t;

	typedef struct packed {
		bus_pins_t meta;
		bus_pins_t pins;
		logic strobe_mode;
		logic [3:0] rst_cnt;
		logic pin_reset;
		logic rd_lvl;
		logic wr_lvl;
		reg_access_t wr_hold;
		logic [1:0] buf_v;
		reg_access_t [1:0] buf_e;
		logic overrun;
		logic rd_req;
		reg_access_t rd_acc;
		logic [7:0] dout;
		logic dout_oe;
	} port_state_t;

	localparam chan_pins_t CHAN_PINS_RST = '{serial_out: 1'h1, rts_n: 1'h1, dtr_n: 1'h1,
		op2_n: 1'h1, tx_rdy_n: 1'h1, rx_rdy_n: 1'h1, irq_o: 1'h0, irq_oe: 1'h0};
	localparam chan_stat_t CHAN_STAT_RST = '{rx_bit: 1'h1, default: 1'h0};
	localparam port_state_t PORT_RST = '0;

endpackage

// ---- logic/chan_pin_unit.sv ----
// one channel's serial, modem, ready and interrupt pins
// assumes rst already merges the chip reset; modem inputs arrive raw from pins
`timescale 1ns/1ps
module chan_pin_unit import duart_port_pkg::*; #(
	parameter bit IS_CHAN_A = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic strobe_mode,
	input wire logic irq_any,
	input wire chan_ctrl_t ctrl,
	input wire modem_in_t modem_in,
	output chan_pins_t pins,
	output chan_stat_t stat
);

	chan_state_t st;
	chan_state_t nxt;
	logic ir;
	logic op2;

	assign ir = ctrl.modem_control_reg[MCR_IR_BIT];
	assign op2 = ctrl.modem_control_reg[MCR_OP2_BIT];

	always_comb begin
		nxt = st;
		nxt.meta = modem_in;
		nxt.sync = st.meta;
		nxt.pins.serial_out = ir ? (ctrl.tx_busy & ctrl.tx_bit) : (~ctrl.tx_busy | ctrl.tx_bit);
		nxt.pins.rts_n = ~ctrl.rts_on;
		nxt.pins.dtr_n = ~ctrl.dtr_on;
		nxt.pins.tx_rdy_n = ~ctrl.tx_space;
		nxt.pins.rx_rdy_n = ~ctrl.rx_avail;
		nxt.pins.op2_n = ~op2;
		if (strobe_mode) begin
			nxt.pins.irq_o = ctrl.irq_pending;
			nxt.pins.irq_oe = op2;
		end else begin
			// shared open-drain interrupt on channel A
			nxt.pins.irq_o = 1'h0;
			nxt.pins.irq_oe = IS_CHAN_A ? irq_any : 1'h0;
		end
		nxt.stat.rx_bit = st.sync.serial_in ^ (ir & ctrl.ir_invert);
		nxt.stat.cts = ~st.sync.cts_n;
		nxt.stat.dsr = ~st.sync.dsr_n;
		nxt.stat.cd = ~st.sync.cd_n;
		nxt.stat.ri = ~st.sync.ri_n;
		nxt.stat.tx_allowed = ~ctrl.auto_cts | ~st.sync.cts_n;
	end

	always_ff @(posedge clk) begin
		st <= nxt;
		if (rst) begin
			st.pins <= CHAN_PINS_RST;
			st.stat <= CHAN_STAT_RST;
		end
	end

	assign pins = st.pins;
	assign stat = st.stat;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_OP2_IRQ: assert property (strobe_mode |=> (st.pins.irq_oe == $past(op2))
		&& (st.pins.op2_n == !$past(op2))) else $error("irq enable not following op2");
	AST_SHARED_IRQ: assert property (!strobe_mode |=> !st.pins.irq_o
		&& (st.pins.irq_oe == (IS_CHAN_A && $past(irq_any)))) else $error("shared irq wrong");
	AST_READY: assert property (1'b1 |=> (st.pins.tx_rdy_n == !$past(ctrl.tx_space))
		&& (st.pins.rx_rdy_n == !$past(ctrl.rx_avail))) else $error("ready pin mismatch");
	AST_STD_IDLE: assert property ((!ir && !ctrl.tx_busy) |=> st.pins.serial_out)
		else $error("standard idle not high");
	AST_IR_IDLE: assert property ((ir && !ctrl.tx_busy) |=> !st.pins.serial_out)
		else $error("infrared idle not low");
	AST_IR_INVERT: assert property ((ir && ctrl.ir_invert) |=> st.stat.rx_bit != $past(st.sync.serial_in))
		else $error("infrared input not inverted");
	AST_RTS: assert property (ctrl.rts_on [*2] |=> !st.pins.rts_n)
		else $error("rts not asserted");
	AST_CTS_GATE: assert property ((ctrl.auto_cts && st.sync.cts_n) |=> !st.stat.tx_allowed)
		else $error("transmit not gated by cts");

endmodule // chan_pin_unit

// ---- logic/duart_host_port.sv ----
// host bus port and pin behaviour of a dual asynchronous serial controller
// assumes the core answers reads in the cycle of rd_req and drains wr_access
`timescale 1ns/1ps
module duart_host_port import duart_port_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic bus_style_strap,
	input wire logic chip_reset_pin,
	input wire logic [2:0] register_select_lines,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic channel_a_select_n,
	// doubles as channel_address_bit in single-strobe mode
	input wire logic channel_b_select_n,
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe,
	input wire logic serial_in_a,
	input wire logic clear_to_send_a_n,
	input wire logic set_ready_a_n,
	input wire logic carrier_detect_a_n,
	input wire logic ring_indicator_a_n,
	input wire logic serial_in_b,
	input wire logic clear_to_send_b_n,
	input wire logic set_ready_b_n,
	input wire logic carrier_detect_b_n,
	input wire logic ring_indicator_b_n,
	output logic serial_out_a,
	output logic request_to_send_a_n,
	output logic terminal_ready_a_n,
	output logic output_port2_a_n,
	output logic transmit_ready_a_n,
	output logic receive_ready_a_n,
	output logic irq_out_channel_a,
	output logic irq_out_channel_a_oe,
	output logic serial_out_b,
	output logic request_to_send_b_n,
	output logic terminal_ready_b_n,
	output logic output_port2_b_n,
	output logic transmit_ready_b_n,
	output logic receive_ready_b_n,
	output logic irq_out_channel_b,
	output logic irq_out_channel_b_oe,
	input wire chan_ctrl_t ctrl_a,
	input wire chan_ctrl_t ctrl_b,
	output chan_stat_t stat_a,
	output chan_stat_t stat_b,
	output logic wr_valid,
	input wire logic wr_ready,
	output reg_access_t wr_access,
	output logic bus_busy,
	output logic write_overrun,
	output logic rd_req,
	output reg_access_t rd_access,
	input wire logic [7:0] rd_data,
	output logic strobe_mode,
	output logic core_reset
);

	port_state_t st;
	port_state_t nxt;
	bus_pins_t pins_now;
	bus_pins_t p;
	logic rp_act;
	logic acc_rd;
	logic acc_wr;
	logic acc_chan;
	logic wr_end;
	logic pop;
	logic chan_rst;
	chan_ctrl_t ctrl_v [NUM_CHAN];
	modem_in_t min_v [NUM_CHAN];
	chan_pins_t pout [NUM_CHAN];
	chan_stat_t stat_v [NUM_CHAN];

	////////////////////////////////////////////////////////////////////////////
	// pin capture
	assign pins_now = '{strap: bus_style_strap, reset_pin: chip_reset_pin,
		rd_n: read_strobe_n, wr_n: write_strobe_n, csa_n: channel_a_select_n,
		csb_n: channel_b_select_n, addr: register_select_lines, din: data_bus_in};
	assign p = st.pins;

	// reset pin polarity follows the strap
	assign rp_act = st.strobe_mode ? p.reset_pin : ~p.reset_pin;

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	always_comb begin
		if (st.strobe_mode) begin
			// exactly one channel select; both low is ignored
			acc_chan = ~p.csb_n;
			// read strobe level, write strobe idle
			acc_rd = (p.csa_n ^ p.csb_n) & ~p.rd_n & p.wr_n;
			// write strobe level, read strobe idle
			acc_wr = (p.csa_n ^ p.csb_n) & ~p.wr_n & p.rd_n;
		end else begin
			// second select acts as channel address bit
			acc_chan = p.csb_n;
			// read strobe ignored, write pin gives direction
			acc_rd = ~p.csa_n & p.wr_n;
			acc_wr = ~p.csa_n & ~p.wr_n;
		end
	end

	assign wr_end = st.wr_lvl & ~acc_wr;
	assign pop = st.buf_v[0] & wr_ready;

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nxt = st;
		nxt.meta = pins_now;
		nxt.pins = st.meta;

		if (!rp_act) begin
			nxt.rst_cnt = 4'h0;
		end else if (st.rst_cnt != RST_CNT_MAX) begin
			nxt.rst_cnt = st.rst_cnt + 4'h1;
		end
		nxt.pin_reset = rp_act & (nxt.rst_cnt == RST_CNT_MAX);

		nxt.rd_lvl = acc_rd;
		nxt.wr_lvl = acc_wr;

		// start internal read on strobe fall
		nxt.rd_req = acc_rd & ~st.rd_lvl;
		if (acc_rd && !st.rd_lvl) begin
			nxt.rd_acc = '{chan: acc_chan, addr: p.addr, data: 8'h00};
		end
		if (st.rd_req) begin
			nxt.dout = rd_data;
		end
		nxt.dout_oe = acc_rd;

		// hold byte while strobe low, commit on release
		if (acc_wr) begin
			nxt.wr_hold = '{chan: acc_chan, addr: p.addr, data: p.din};
		end

		// two-entry buffer; head always in slot 0
		if (pop) begin
			nxt.buf_e[0] = st.buf_e[1];
			nxt.buf_v[0] = st.buf_v[1];
			nxt.buf_v[1] = 1'h0;
		end
		if (wr_end) begin
			if (!nxt.buf_v[0]) begin
				nxt.buf_e[0] = st.wr_hold;
				nxt.buf_v[0] = 1'h1;
			end else if (!nxt.buf_v[1]) begin
				nxt.buf_e[1] = st.wr_hold;
				nxt.buf_v[1] = 1'h1;
			end else begin
				nxt.overrun = 1'h1;
			end
		end

		// chip reset clears the port but keeps pin sampling and the filter
		if (st.pin_reset) begin
			nxt.rd_lvl = 1'h0;
			nxt.wr_lvl = 1'h0;
			nxt.rd_req = 1'h0;
			nxt.dout = 8'h00;
			nxt.dout_oe = 1'h0;
			nxt.buf_v = 2'h0;
			nxt.overrun = 1'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= PORT_RST;
			st.meta <= nxt.meta;
			st.pins <= nxt.pins;
			// strap caught while reset is held
			st.strobe_mode <= st.pins.strap;
		end else begin
			st <= nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// channels
	assign chan_rst = rst | st.pin_reset;
	assign ctrl_v[0] = ctrl_a;
	assign ctrl_v[1] = ctrl_b;
	assign min_v[0] = '{serial_in: serial_in_a, cts_n: clear_to_send_a_n, dsr_n: set_ready_a_n,
		cd_n: carrier_detect_a_n, ri_n: ring_indicator_a_n};
	assign min_v[1] = '{serial_in: serial_in_b, cts_n: clear_to_send_b_n, dsr_n: set_ready_b_n,
		cd_n: carrier_detect_b_n, ri_n: ring_indicator_b_n};

	genvar i;
	for (i = 0; i < NUM_CHAN; i++) begin : g_chan
		chan_pin_unit #(
			.IS_CHAN_A(i == 0)
		) u_chan (
			.clk(clk),
			.rst(chan_rst),
			.strobe_mode(st.strobe_mode),
			.irq_any(ctrl_a.irq_pending | ctrl_b.irq_pending),
			.ctrl(ctrl_v[i]),
			.modem_in(min_v[i]),
			.pins(pout[i]),
			.stat(stat_v[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign data_bus_out = st.dout;
	assign data_bus_oe = st.dout_oe;
	assign wr_valid = st.buf_v[0];
	assign wr_access = st.buf_e[0];
	assign bus_busy = st.buf_v[1];
	assign write_overrun = st.overrun;
	assign rd_req = st.rd_req;
	assign rd_access = st.rd_acc;
	assign strobe_mode = st.strobe_mode;
	assign core_reset = st.pin_reset;
	assign stat_a = stat_v[0];
	assign stat_b = stat_v[1];

	assign serial_out_a = pout[0].serial_out;
	assign request_to_send_a_n = pout[0].rts_n;
	assign terminal_ready_a_n = pout[0].dtr_n;
	assign output_port2_a_n = pout[0].op2_n;
	assign transmit_ready_a_n = pout[0].tx_rdy_n;
	assign receive_ready_a_n = pout[0].rx_rdy_n;
	assign irq_out_channel_a = pout[0].irq_o;
	assign irq_out_channel_a_oe = pout[0].irq_oe;
	assign serial_out_b = pout[1].serial_out;
	assign request_to_send_b_n = pout[1].rts_n;
	assign terminal_ready_b_n = pout[1].dtr_n;
	assign output_port2_b_n = pout[1].op2_n;
	assign transmit_ready_b_n = pout[1].tx_rdy_n;
	assign receive_ready_b_n = pout[1].rx_rdy_n;
	assign irq_out_channel_b = pout[1].irq_o;
	assign irq_out_channel_b_oe = pout[1].irq_oe;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst || st.pin_reset);

	AST_RD_ADDR: assert property (st.rd_req |-> st.rd_acc.addr == $past(st.pins.addr))
		else $error("read address not from select lines");
	AST_RD_START: assert property ((acc_rd && !st.rd_lvl) |=> st.rd_req && st.dout_oe)
		else $error("read not started on strobe fall");
	AST_RD_DATA: assert property (st.rd_req |=> (st.dout == $past(rd_data)) [*2])
		else $error("read byte not driven");
	AST_WR_CAPTURE: assert property ((wr_end && st.buf_v == 2'h0) |=> st.buf_v[0]
		&& (st.buf_e[0] == $past(st.wr_hold))) else $error("write byte not captured");
	AST_SINGLE_DIR: assert property ((!st.strobe_mode && st.rd_req) |->
		$past(st.pins.wr_n) && !$past(st.pins.csa_n)) else $error("direction level ignored");
	AST_STROBE_CHAN: assert property ((st.strobe_mode && st.rd_req) |->
		(st.rd_acc.chan == !$past(st.pins.csb_n)) && ($past(st.pins.csa_n) != $past(st.pins.csb_n)))
		else $error("channel select wrong");
	AST_SINGLE_CHAN: assert property ((!st.strobe_mode && st.rd_req) |->
		st.rd_acc.chan == $past(st.pins.csb_n)) else $error("address bit channel wrong");
	AST_RST_PULSE: assert property (@(posedge clk) disable iff (rst)
		rp_act [*8] |=> st.pin_reset) else $error("qualified reset pulse not taken");
	AST_RST_SHORT: assert property (@(posedge clk) disable iff (rst)
		!rp_act |=> !st.pin_reset) else $error("reset taken without active pin");

endmodule // duart_host_port

// ---- sim/host_bus_model.sv ----
// host processor model driving the parallel bus pins of the port
// assumes the bench supplies clk and the strap level it reset with
`timescale 1ns/1ps
module host_bus_model import duart_port_pkg::*; (
	input wire logic clk,
	input wire logic strobe_style,
	input wire logic [7:0] data_bus_out,
	output logic [2:0] register_select_lines,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic channel_a_select_n,
	output logic channel_b_select_n,
	output logic [7:0] data_bus_in
);
	initial begin
		register_select_lines = 3'h0;
		read_strobe_n = 1'h1;
		write_strobe_n = 1'h1;
		channel_a_select_n = 1'h1;
		channel_b_select_n = 1'h1;
		data_bus_in = 8'h00;
	end

	////////////////////////////////////////////////////////////
	// ch: 0 channel a, 1 channel b, 2 both selects
	task automatic xfer(input logic [1:0] ch, input logic [2:0] a, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		register_select_lines = a;
		data_bus_in = d;
		if (strobe_style) begin
			channel_a_select_n = (ch == 2'h1);
			channel_b_select_n = (ch == 2'h0);
			read_strobe_n = wr;
			write_strobe_n = !wr;
		end else begin
			channel_a_select_n = 1'h0;
			channel_b_select_n = ch[0];
			write_strobe_n = !wr;
		end
		repeat (8) @(negedge clk);
		q = data_bus_out;
		read_strobe_n = 1'h1;
		write_strobe_n = 1'h1;
		channel_a_select_n = 1'h1;
		channel_b_select_n = 1'h1;
		// released bus holds no stale byte
		data_bus_in = ~d;
		repeat (6) @(negedge clk);
	endtask
endmodule // host_bus_model

// ---- sim/tb.sv ----
// self-checking bench for the dual serial host port
// assumes host_bus_model drives the bus; the bench plays the core side
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb import duart_port_pkg::*;;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic strap = 1'h1;
	logic chip_rst = 1'h0;
	logic wr_ready = 1'h0;
	chan_ctrl_t ctrl_a = '0;
	chan_ctrl_t ctrl_b = '0;
	modem_in_t min_a = '1;
	modem_in_t min_b = '1;
	logic [2:0] sel;
	logic rs_n, ws_n, csa_n, csb_n;
	logic [7:0] din, dout, q, rd_data;
	logic oe, sa, sb, dtr_a_n, rts_b_n, op2_a_n, op2_b_n, txr_a_n, txr_b_n, rxr_a_n;
	logic irq_a, irq_a_oe, irq_b_oe, wr_valid, bus_busy, ovr, smode, core_rst;
	logic rts_a_n, dtr_b_n, rxr_b_n, irq_b;
	reg_access_t wr_acc, rd_acc;
	chan_stat_t stat_a, stat_b;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #2.5 clk = ~clk;
	assign rd_data = {1'h1, rd_acc.chan, 3'h0, rd_acc.addr};

	duart_host_port dut_u (.clk(clk), .rst(rst), .bus_style_strap(strap),
		.chip_reset_pin(chip_rst), .register_select_lines(sel), .read_strobe_n(rs_n),
		.write_strobe_n(ws_n), .channel_a_select_n(csa_n), .channel_b_select_n(csb_n),
		.data_bus_in(din), .data_bus_out(dout), .data_bus_oe(oe),
		.serial_in_a(min_a.serial_in), .clear_to_send_a_n(min_a.cts_n),
		.set_ready_a_n(min_a.dsr_n), .carrier_detect_a_n(min_a.cd_n),
		.ring_indicator_a_n(min_a.ri_n), .serial_in_b(min_b.serial_in),
		.clear_to_send_b_n(min_b.cts_n), .set_ready_b_n(min_b.dsr_n),
		.carrier_detect_b_n(min_b.cd_n), .ring_indicator_b_n(min_b.ri_n),
		.serial_out_a(sa), .request_to_send_a_n(rts_a_n), .terminal_ready_a_n(dtr_a_n),
		.output_port2_a_n(op2_a_n), .transmit_ready_a_n(txr_a_n),
		.receive_ready_a_n(rxr_a_n), .irq_out_channel_a(irq_a),
		.irq_out_channel_a_oe(irq_a_oe), .serial_out_b(sb), .request_to_send_b_n(rts_b_n),
		.terminal_ready_b_n(dtr_b_n), .output_port2_b_n(op2_b_n), .transmit_ready_b_n(txr_b_n),
		.receive_ready_b_n(rxr_b_n), .irq_out_channel_b(irq_b), .irq_out_channel_b_oe(irq_b_oe),
		.ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .stat_a(stat_a), .stat_b(stat_b),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_access(wr_acc), .bus_busy(bus_busy),
		.write_overrun(ovr), .rd_req(), .rd_access(rd_acc), .rd_data(rd_data),
		.strobe_mode(smode), .core_reset(core_rst));

	host_bus_model host_u (.clk(clk), .strobe_style(strap), .data_bus_out(dout),
		.register_select_lines(sel), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
		.channel_a_select_n(csa_n), .channel_b_select_n(csb_n), .data_bus_in(din));

	////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic settle();
		repeat (5) @(negedge clk);
	endtask

	task automatic do_reset(input logic s);
		rst = 1'h1;
		strap = s;
		chip_rst = !s;
		repeat (10) @(negedge clk);
		rst = 1'h0;
		settle();
	endtask

	// takes one word off the write stream
	task automatic pop(input reg_access_t e);
		for (int i = 0; i < 20 && wr_valid !== 1'h1; i++) @(negedge clk);
		`CHK({wr_valid, wr_acc}, {1'h1, e})
		wr_ready = 1'h1;
		@(negedge clk);
		wr_ready = 1'h0;
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'h1);
		`CHK({sa, sb, op2_a_n, oe, wr_valid, smode}, 6'h39)
		// fill the buffer, third write dropped
		host_u.xfer(2'h0, 3'h5, 1'h1, 8'h3c, q);
		host_u.xfer(2'h1, 3'h2, 1'h1, 8'hc3, q);
		`CHK({bus_busy, ovr}, 2'h2)
		host_u.xfer(2'h0, 3'h7, 1'h1, 8'h55, q);
		`CHK(ovr, 1'h1)
		pop('{chan: 1'h0, addr: 3'h5, data: 8'h3c});
		pop('{chan: 1'h1, addr: 3'h2, data: 8'hc3});
		settle();
		`CHK(wr_valid, 1'h0)
		host_u.xfer(2'h2, 3'h1, 1'h1, 8'h11, q);
		`CHK(wr_valid, 1'h0)
		for (int c = 0; c < 2; c++) begin
			host_u.xfer(2'(c), 3'h6, 1'h0, 8'h00, q);
			`CHK(q, {1'h1, 1'(c), 3'h0, 3'h6})
			`CHK(oe, 1'h0)
		end
		// op2 enables the interrupt pin and also drives op2_n low
		ctrl_a.modem_control_reg[MCR_OP2_BIT] = 1'h1;
		ctrl_a.irq_pending = 1'h1;
		ctrl_b.irq_pending = 1'h1;
		ctrl_b.tx_space = 1'h1;
		// rts asserted in the same step as flow control enabled
		ctrl_b.rts_on = 1'h1;
		ctrl_b.auto_cts = 1'h1;
		ctrl_a.rx_avail = 1'h1;
		ctrl_a.dtr_on = 1'h1;
		min_a.cts_n = 1'h0;
		min_b.ri_n = 1'h0;
		settle();
		`CHK({op2_a_n, irq_a_oe, irq_a, op2_b_n, irq_b_oe}, 5'h0e)
		`CHK({txr_b_n, rts_b_n, rxr_a_n, dtr_a_n, txr_a_n}, 5'h01)
		`CHK({rts_a_n, dtr_b_n}, 2'h3)
		`CHK({rxr_b_n, irq_b}, 2'h3)
		`CHK({stat_a.cts, stat_b.ri, stat_b.cts, stat_a.dsr}, 4'hc)
		`CHK({stat_a.tx_allowed, stat_b.tx_allowed}, 2'h2)
		min_b.cts_n = 1'h0;
		settle();
		`CHK(stat_b.tx_allowed, 1'h1)
		for (int k = 0; k < 8; k++) begin
			{ctrl_a.modem_control_reg[MCR_IR_BIT], ctrl_a.tx_busy, ctrl_a.tx_bit} = 3'(k);
			settle();
			`CHK(sa, k[2] ? k[1] & k[0] : !k[1] | k[0])
		end
		ctrl_a.ir_invert = 1'h1;
		ctrl_b.ir_invert = 1'h1;
		min_a.serial_in = 1'h0;
		min_b.serial_in = 1'h0;
		settle();
		`CHK({stat_a.rx_bit, stat_b.rx_bit}, 2'h2)
		ctrl_a.modem_control_reg[MCR_IR_BIT] = 1'h0;
		ctrl_a.tx_bit = 1'h0;
		chip_rst = 1'h1;
		repeat (14) @(negedge clk);
		`CHK({core_rst, sa, op2_a_n}, 3'h7)
		chip_rst = 1'h0;
		settle();
		`CHK({core_rst, sa}, 2'h0)
		chip_rst = 1'h1;
		repeat (7) @(negedge clk);
		`CHK(core_rst, 1'h0)
		chip_rst = 1'h0;
		// single-strobe bus
		ctrl_a = '0;
		ctrl_b = '0;
		ctrl_b.irq_pending = 1'h1;
		do_reset(1'h0);
		`CHK({smode, irq_a_oe, irq_a, irq_b_oe}, 4'h4)
		host_u.xfer(2'h1, 3'h3, 1'h1, 8'ha5, q);
		pop('{chan: 1'h1, addr: 3'h3, data: 8'ha5});
		host_u.xfer(2'h0, 3'h4, 1'h0, 8'h00, q);
		`CHK(q, 8'h84)
		summarize();
	end
endmodule // tb
